// file: ohbfe_params.svh
// Overview of operation
// - straps bit2..bit0 pick bus: 110 8080, 010 I2C, 100 6800, 000 SPI4, 001 SPI3.
// - oscillator select high runs internal oscillator and drives it out on clock pad.
// - transfers are accepted only while chip select is held low.
// - data bus lines float while chip select is inactive.
// - low level on init pin resets all settings for as long as held.
// - data/command select high marks the byte as display data.
// - data/command select low sends the byte to the command registers.
// - in I2C the data/command pin is the low slave address bit.
// - 8080 write strobe is active low; data taken on its rising edge.
// - 8080 bus is driven only while the read strobe is low.
// - 6800 strobe pin is an active-high enable qualifying transfers.
// - SPI uses bit 0 as clock, bit 1 as data, others float.
// - I2C uses bit 0 as SCL, bit 1 as SDA, others float.
// - frame marker high while the last row of each frame is driven.
// - parallel path is an eight-bit bidirectional bus, one byte per transfer.
// - I2C fast mode up to its stated maximum clock rate.
// - display data goes to a 384 by 96 memory of 4-bit pixels.
`ifndef OHBFE_PARAMS_SVH
`define OHBFE_PARAMS_SVH
`define OHB_COLS 384
`define OHB_ROWS 96
`define OHB_PIX_BITS 4
`define OHB_COL_W 9
`define OHB_ROW_W 7
`define OHB_PIX_STEP 9'd2
`define OHB_SPI4_BITS 4'd8
`define OHB_SPI3_BITS 4'd9
`define OHB_I2C_BITS 4'd8
// upper six address bits; value is arbitrary
`define OHB_I2C_ADDR_HI 6'h1e
`define OHB_OSC_HALF 8'd4
`define OHB_DCLK_PER_ROW 16
`define OHB_BOOT_CYC 3'd6
`define OHB_PIN_W 18
`define OHB_PIN_D0 0
`define OHB_PIN_D1 1
`define OHB_PIN_CS 8
`define OHB_PIN_DC 9
`define OHB_PIN_WR 10
`define OHB_PIN_RD 11
`define OHB_PIN_OSC 12
`define OHB_PIN_INIT 13
`define OHB_PIN_OSEL 14
`define OHB_PIN_M0 15
`define OHB_PIN_M2 17
`endif

// file: ohbfe_pkg.sv
`include "ohbfe_params.svh"
package ohbfe_pkg;
    typedef enum logic [2:0] {
        OHBFE_M_SPI4 = 3'b000,
        OHBFE_M_SPI3 = 3'b001,
        OHBFE_M_I2C = 3'b010,
        OHBFE_M_6800 = 3'b100,
        OHBFE_M_8080 = 3'b110,
        OHBFE_M_NONE = 3'b111
    } ohbfe_mode_t;

    typedef enum logic [2:0] {
        OHBFE_I_IDLE = 3'b000,
        OHBFE_I_ADDR = 3'b001,
        OHBFE_I_CTRL = 3'b010,
        OHBFE_I_DATA = 3'b011,
        OHBFE_I_IGN = 3'b100
    } ohbfe_i2c_t;

    typedef struct packed {
        logic dc;
        logic [7:0] b;
    } ohbfe_ent_t;

    typedef struct packed {
        logic [`OHB_PIN_W-1:0] s1;
        logic [`OHB_PIN_W-1:0] s2;
        logic [`OHB_PIN_W-1:0] s3;
        logic [`OHB_PIN_W-1:0] f;
        logic [`OHB_PIN_W-1:0] fp;
        logic [2:0] boot;
        ohbfe_mode_t mode;
        logic pend_v;
        ohbfe_ent_t pend;
        logic overrun;
        logic [8:0] sh;
        logic [3:0] cnt;
        ohbfe_i2c_t ist;
        logic ack;
        logic co;
        logic idc;
        ohbfe_ent_t [1:0] fifo;
        logic wp;
        logic rp;
        logic [1:0] n;
        logic [7:0] dout;
        logic rd_act;
        logic rd_done;
        logic [7:0] odiv;
        logic olvl;
        logic [7:0] dcnt;
        logic [`OHB_ROW_W-1:0] line;
        logic frame;
        logic [`OHB_COL_W-1:0] col;
        logic [`OHB_ROW_W-1:0] row;
    } ohbfe_st_t;
endpackage

// file: ohbfe_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ohbfe_params.svh"
module ohbfe_top
    import ohbfe_pkg::*;
#(
    parameter int COLS = `OHB_COLS,
    parameter int ROWS = `OHB_ROWS,
    parameter int DCLK_PER_ROW = `OHB_DCLK_PER_ROW
) (
    input wire logic sys_clk, // 100 MHz
    input wire logic rst, // sync, active high
    input wire logic iface_mode_bit0, // strap
    input wire logic iface_mode_bit1, // strap
    input wire logic iface_mode_bit2, // strap
    input wire logic internal_osc_select, // 1 = internal osc
    input wire logic osc_io_pad_in, // clock pad level
    output logic osc_io_pad_out, // internal clock out
    output logic osc_io_pad_oe, // drives clock pad
    input wire logic hw_init_n, // level init, low active
    input wire logic chip_sel_n, // chip select
    input wire logic data_command_select, // data/cmd or addr bit
    input wire logic wr_strobe_n, // 8080 write / 6800 r/w
    input wire logic rd_strobe_n, // 8080 read / 6800 enable
    input wire logic [7:0] bus_in, // data bus pins in
    output logic [7:0] bus_out, // data bus pins out
    output logic [7:0] bus_oe, // per-line drive enable
    input wire logic [7:0] rd_data, // byte for host reads
    output logic rd_done, // pulse: host read ended
    output logic out_valid, // buffered byte ready
    input wire logic out_ready, // consumer takes byte
    output logic [7:0] out_byte, // buffered byte
    output logic out_is_data, // 1 display data, 0 command
    output logic [`OHB_COL_W-1:0] out_col, // first pixel column
    output logic [`OHB_ROW_W-1:0] out_row, // pixel row
    output logic frame_marker, // last row active
    output logic overrun, // sticky: byte lost
    output logic [2:0] active_mode, // latched strap mode
    output logic in_init // init in progress
);
    // refuse geometry the counters cannot hold
    if (COLS < 2 || COLS > (1 << `OHB_COL_W) || (COLS % 2) != 0 ||
        ROWS < 2 || ROWS > (1 << `OHB_ROW_W) || DCLK_PER_ROW < 1 ||
        DCLK_PER_ROW > 256) begin : g_bad_geom
        $error("ohbfe_top: unsupported geometry");
    end

    localparam logic [`OHB_COL_W-1:0] COL_LAST = `OHB_COL_W'(COLS - 2);
    localparam logic [`OHB_ROW_W-1:0] ROW_LAST = `OHB_ROW_W'(ROWS - 1);
    localparam logic [7:0] DCNT_LAST = 8'(DCLK_PER_ROW - 1);

    ohbfe_st_t q, d;
    logic [`OHB_PIN_W-1:0] pins, agree, rise, fall;
    logic init, sel, cap, push, pop, tick;
    logic i2c_start, i2c_stop;
    logic [3:0] need;
    ohbfe_ent_t cent;

    assign pins = {iface_mode_bit2, iface_mode_bit1, iface_mode_bit0,
                   internal_osc_select, hw_init_n, osc_io_pad_in,
                   rd_strobe_n, wr_strobe_n, data_command_select,
                   chip_sel_n, bus_in};

    // pin edges seen only on the filtered copy
    assign agree = ~(q.s2 ^ q.s3);
    assign rise = q.f & ~q.fp;
    assign fall = ~q.f & q.fp;
    assign init = ~q.f[`OHB_PIN_INIT] | (q.boot != `OHB_BOOT_CYC);
    assign sel = ~q.f[`OHB_PIN_CS];
    assign i2c_start = q.f[`OHB_PIN_D0] & q.fp[`OHB_PIN_D0] & fall[`OHB_PIN_D1];
    assign i2c_stop = q.f[`OHB_PIN_D0] & q.fp[`OHB_PIN_D0] & rise[`OHB_PIN_D1];
    assign need = (q.mode == OHBFE_M_SPI3) ? `OHB_SPI3_BITS : `OHB_SPI4_BITS;

    always_comb begin
        d = q;
        cap = 1'b0;
        cent = '0;
        push = 1'b0;
        pop = 1'b0;
        tick = 1'b0;
        // three-stage sync; a change counts once stages two and three agree
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.f = (q.f & ~agree) | (q.s2 & agree);
        d.fp = q.f;
        d.rd_done = 1'b0;
        d.dout = (q.mode == OHBFE_M_I2C) ? 8'h00 : rd_data; // i2c ack pulls low

        // internal oscillator from a divider of the system clock
        if (q.f[`OHB_PIN_OSEL]) begin
            if (q.odiv == `OHB_OSC_HALF - 8'd1) begin
                d.odiv = 8'h00;
                d.olvl = ~q.olvl;
                tick = ~q.olvl;
            end else begin
                d.odiv = q.odiv + 8'd1;
            end
        end else begin
            d.odiv = 8'h00;
            d.olvl = 1'b0;
            tick = rise[`OHB_PIN_OSC];
        end

        // row scan; marker follows the last row
        if (tick) begin
            if (q.dcnt == DCNT_LAST) begin
                d.dcnt = 8'h00;
                d.line = (q.line == ROW_LAST) ? '0 : q.line + `OHB_ROW_W'(1);
            end else begin
                d.dcnt = q.dcnt + 8'd1;
            end
        end
        d.frame = (d.line == ROW_LAST);

        // pending byte moves into the two-entry buffer when there is room
        if (q.pend_v && q.n != 2'd2) begin
            push = 1'b1;
            d.fifo[q.wp] = q.pend;
            d.wp = ~q.wp;
            d.pend_v = 1'b0;
        end
        pop = (q.n != 2'd0) && out_ready;
        if (pop) begin
            d.rp = ~q.rp;
            // display data walks the pixel address, two pixels a byte
            if (q.fifo[q.rp].dc) begin
                if (q.col >= COL_LAST) begin
                    d.col = '0;
                    d.row = (q.row == ROW_LAST) ? '0 : q.row + `OHB_ROW_W'(1);
                end else begin
                    d.col = q.col + `OHB_PIX_STEP;
                end
            end
        end
        d.n = q.n + {1'b0, push} - {1'b0, pop};

        if (init) begin
            // settings back to start; straps taken while init holds
            if (q.boot != `OHB_BOOT_CYC) begin
                d.boot = q.boot + 3'd1;
            end
            case (q.f[`OHB_PIN_M2:`OHB_PIN_M0])
                3'b110: d.mode = OHBFE_M_8080;
                3'b010: d.mode = OHBFE_M_I2C;
                3'b100: d.mode = OHBFE_M_6800;
                3'b000: d.mode = OHBFE_M_SPI4;
                3'b001: d.mode = OHBFE_M_SPI3;
                default: d.mode = OHBFE_M_NONE;
            endcase
            d.pend_v = 1'b0;
            d.overrun = 1'b0;
            d.sh = '0;
            d.cnt = 4'h0;
            d.ist = OHBFE_I_IDLE;
            d.ack = 1'b0;
            d.rd_act = 1'b0;
            d.n = 2'd0;
            d.wp = 1'b0;
            d.rp = 1'b0;
            d.col = '0;
            d.row = '0;
        end else if (!sel) begin
            // deselected: bus floats and serial framing restarts
            d.cnt = 4'h0;
            d.ist = OHBFE_I_IDLE;
            d.ack = 1'b0;
            d.rd_act = 1'b0;
        end else begin
            case (q.mode)
                OHBFE_M_8080: begin
                    d.rd_act = ~q.f[`OHB_PIN_RD];
                    d.rd_done = rise[`OHB_PIN_RD];
                    if (rise[`OHB_PIN_WR]) begin
                        cap = 1'b1;
                        cent = {q.f[`OHB_PIN_DC], q.f[7:0]};
                    end
                end
                OHBFE_M_6800: begin
                    // enable high qualifies; r/w high reads
                    d.rd_act = q.f[`OHB_PIN_RD] & q.f[`OHB_PIN_WR];
                    d.rd_done = fall[`OHB_PIN_RD] & q.f[`OHB_PIN_WR];
                    if (fall[`OHB_PIN_RD] && !q.f[`OHB_PIN_WR]) begin
                        cap = 1'b1;
                        cent = {q.f[`OHB_PIN_DC], q.f[7:0]};
                    end
                end
                OHBFE_M_SPI4, OHBFE_M_SPI3: begin
                    if (rise[`OHB_PIN_D0]) begin
                        d.sh = {q.sh[7:0], q.f[`OHB_PIN_D1]};
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt + 4'h1 == need) begin
                            d.cnt = 4'h0;
                            cap = 1'b1;
                            // three-wire frames carry the data/command flag first
                            cent.dc = (q.mode == OHBFE_M_SPI3) ? q.sh[7] : q.f[`OHB_PIN_DC];
                            cent.b = {q.sh[6:0], q.f[`OHB_PIN_D1]};
                        end
                    end
                end
                OHBFE_M_I2C: begin
                    // only filtered edges; fine for fast mode at this clock
                    if (i2c_start) begin
                        d.ist = OHBFE_I_ADDR;
                        d.cnt = 4'h0;
                        d.ack = 1'b0;
                    end else if (i2c_stop) begin
                        d.ist = OHBFE_I_IDLE;
                        d.ack = 1'b0;
                    end else if (rise[`OHB_PIN_D0] && q.ist != OHBFE_I_IDLE &&
                                 q.ist != OHBFE_I_IGN) begin
                        d.sh = {q.sh[7:0], q.f[`OHB_PIN_D1]};
                        d.cnt = q.cnt + 4'h1;
                    end else if (fall[`OHB_PIN_D0]) begin
                        if (q.ack) begin
                            d.ack = 1'b0;
                            d.cnt = 4'h0;
                        end else if (q.cnt == `OHB_I2C_BITS) begin
                            case (q.ist)
                                OHBFE_I_ADDR: begin
                                    // write to our address only
                                    if (q.sh[7:0] == {`OHB_I2C_ADDR_HI,
                                        q.f[`OHB_PIN_DC], 1'b0}) begin
                                        d.ist = OHBFE_I_CTRL;
                                        d.ack = 1'b1;
                                    end else begin
                                        d.ist = OHBFE_I_IGN;
                                    end
                                end
                                OHBFE_I_CTRL: begin
                                    d.co = q.sh[7];
                                    d.idc = q.sh[6];
                                    d.ist = OHBFE_I_DATA;
                                    d.ack = 1'b1;
                                end
                                OHBFE_I_DATA: begin
                                    cap = 1'b1;
                                    cent = {q.idc, q.sh[7:0]};
                                    d.ack = 1'b1;
                                    if (q.co) begin
                                        d.ist = OHBFE_I_CTRL;
                                    end
                                end
                                default: d.ist = q.ist;
                            endcase
                        end
                    end
                end
                default: d.rd_act = 1'b0;
            endcase
        end

        // a capture while the pending slot is still full is lost, and flagged
        if (cap) begin
            if (d.pend_v) begin
                d.overrun = 1'b1;
            end else begin
                d.pend_v = 1'b1;
                d.pend = cent;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // pin drive: parallel reads drive all lines, i2c ack only line 1
    always_comb begin
        bus_oe = 8'h00;
        if (!init && sel) begin
            if ((q.mode == OHBFE_M_8080 || q.mode == OHBFE_M_6800) && q.rd_act) begin
                bus_oe = 8'hff;
            end else if (q.mode == OHBFE_M_I2C && q.ack) begin
                bus_oe = 8'h02;
            end
        end
    end
    assign bus_out = q.dout;
    assign rd_done = q.rd_done;
    assign osc_io_pad_out = q.olvl;
    assign osc_io_pad_oe = q.f[`OHB_PIN_OSEL];
    assign out_valid = (q.n != 2'd0);
    assign out_byte = q.fifo[q.rp].b;
    assign out_is_data = q.fifo[q.rp].dc;
    assign out_col = q.col;
    assign out_row = q.row;
    assign frame_marker = q.frame;
    assign overrun = q.overrun;
    assign active_mode = q.mode;
    assign in_init = init;
endmodule
`default_nettype wire

// file: ohbfe_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ohbfe_sva (
    input wire logic sys_clk, // clock
    input wire logic rst, // sync reset
    input wire logic internal_osc_select, // osc select
    input wire logic osc_io_pad_oe, // pad drive
    input wire logic hw_init_n, // init pin
    input wire logic chip_sel_n, // select
    input wire logic rd_strobe_n, // read strobe
    input wire logic [7:0] bus_oe, // bus drive
    input wire logic out_valid, // head valid
    input wire logic out_ready, // head taken
    input wire logic [7:0] out_byte, // head byte
    input wire logic frame_marker, // last row
    input wire logic overrun, // byte lost
    input wire logic [2:0] active_mode // latched mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0] idle_q;
    // cycles since last select; saturates so long gaps stay cheap
    always_ff @(posedge sys_clk) begin
        if (rst || !chip_sel_n) idle_q <= 4'h0;
        else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
    end
    sequence s_unsel; chip_sel_n [*8]; endsequence
    sequence s_rd; (active_mode == 3'b110 && !chip_sel_n && !rd_strobe_n) [*8]; endsequence
    sequence s_norm; (active_mode == 3'b110 && rd_strobe_n) [*8]; endsequence
    sequence s_up; hw_init_n [*6]; endsequence
    AST_CS_FLOAT: assert property (s_unsel |-> bus_oe == 8'h00)
        else $error("bus driven while deselected");
    AST_RD_DRIVE: assert property (s_rd |-> bus_oe == 8'hff)
        else $error("bus not driven during read");
    AST_RD_IDLE: assert property (s_norm |-> bus_oe == 8'h00)
        else $error("bus driven without read strobe");
    AST_SPI_LINES: assert property (active_mode inside {3'b000, 3'b001} |-> bus_oe == 8'h00)
        else $error("serial mode drives bus");
    AST_I2C_LINES: assert property (active_mode == 3'b010 |-> bus_oe[7:2] == 6'h00 && !bus_oe[0])
        else $error("i2c mode drives unused lines");
    AST_INIT_CLEAR: assert property (!hw_init_n [*8] |-> !out_valid && !overrun)
        else $error("init does not clear state");
    AST_HOLD_HEAD: assert property (s_up ##0 (out_valid && !out_ready) |=> out_valid && $stable(out_byte))
        else $error("stalled head lost");
    AST_OVR_STICKY: assert property (s_up ##0 overrun |=> overrun)
        else $error("overrun cleared without init");
    AST_ONLY_SEL: assert property ($rose(out_valid) |-> idle_q < 4'hc)
        else $error("byte taken while deselected");
    AST_FRAME_ROW: assert property ($rose(frame_marker) |-> frame_marker [*8])
        else $error("frame marker too short");
    AST_OSC_OUT: assert property (internal_osc_select [*6] |-> osc_io_pad_oe)
        else $error("internal clock not driven out");
    AST_OSC_IN: assert property (!internal_osc_select [*6] |-> !osc_io_pad_oe)
        else $error("pad driven in external mode");
endmodule
bind ohbfe_top ohbfe_sva u_sva (.sys_clk, .rst, .internal_osc_select, .osc_io_pad_oe,
    .hw_init_n, .chip_sel_n, .rd_strobe_n, .bus_oe, .out_valid, .out_ready, .out_byte,
    .frame_marker, .overrun, .active_mode);
`default_nettype wire

// file: ohbfe_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ohbfe_host_model (
    input wire logic sys_clk, // bench clock
    input wire logic [7:0] dev_out, // device drive
    input wire logic [7:0] dev_oe, // device enables
    input wire logic ext_en, // run pad clock
    output logic cs_n = 1'b1, // select
    output logic dc = 1'b0, // data/command
    output logic wr_n = 1'b1, // write strobe or r/w
    output logic rd_n = 1'b1, // read strobe or enable
    output logic pad_clk = 1'b0, // display clock
    output logic [7:0] pins // resolved bus
);
    logic [7:0] hv = 8'h00;
    logic [7:0] last = 8'h00;
    logic hoe = 1'b0;
    // released lines show the inverse so a stale byte never matches
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pins[i] = dev_oe[i] ? dev_out[i] : (hoe ? hv[i] : ~last[i]);
        end
    end
    always @(negedge sys_clk) if (hoe) last <= hv;
    // display clock only within runs, phase unrelated to sys_clk
    initial begin
        #3;
        forever #40 pad_clk = ext_en ? ~pad_clk : 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic m68, input logic sel, input logic d, input logic [7:0] b);
        cs_n = ~sel;
        dc = d;
        hv = b;
        hoe = 1'b1;
        wr_n = 1'b0;
        hold(5);
        if (m68) begin
            rd_n = 1'b1;
            hold(5);
            rd_n = 1'b0;
        end else begin
            wr_n = 1'b1;
        end
        hold(5);
        hoe = 1'b0;
        cs_n = 1'b1;
        wr_n = 1'b1;
        hold(5);
    endtask
    task automatic rd(input logic m68, output logic [7:0] v, output logic [7:0] oe);
        cs_n = 1'b0;
        wr_n = 1'b1;
        rd_n = m68;
        hold(10);
        v = pins;
        oe = dev_oe;
        rd_n = ~m68;
        hold(10);
        cs_n = 1'b1;
        hold(3);
    endtask
    // one i2c byte plus its ack clock; start before the first, stop after the last
    task automatic i2c(input logic [7:0] b, input logic first, input logic last);
        if (first) begin
            hoe = 1'b1;
            cs_n = 1'b0;
            hv = 8'h03;
            hold(4);
            hv[1] = 1'b0;
            hold(4);
            hv[0] = 1'b0;
            hold(4);
        end
        for (int i = 8; i >= 0; i--) begin
            hv[1] = (i == 0) ? 1'b1 : b[i - 1];
            hold(4);
            hv[0] = 1'b1;
            hold(4);
            hv[0] = 1'b0;
            hold(4);
        end
        if (last) begin
            hv[1] = 1'b0;
            hold(4);
            hv[0] = 1'b1;
            hold(4);
            hv[1] = 1'b1;
            hold(4);
            hoe = 1'b0;
            cs_n = 1'b1;
            hold(4);
        end
    endtask
    task automatic spi(input logic three, input logic d, input logic [7:0] b);
        logic [8:0] s;
        s = {d, b};
        cs_n = 1'b0;
        dc = d;
        hoe = 1'b1;
        hv = 8'h00;
        hold(4);
        for (int i = three ? 8 : 7; i >= 0; i--) begin
            hv = {6'h00, s[i], 1'b0};
            hold(4);
            hv[0] = 1'b1;
            hold(4);
        end
        hv[0] = 1'b0;
        hold(4);
        hoe = 1'b0;
        cs_n = 1'b1;
        hold(4);
    endtask
endmodule
`default_nettype wire

// file: ohbfe_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ohbfe_top_tb_top;
    localparam int COLS = 8;
    localparam int ROWS = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] strap = 3'b110;
    logic osel = 1'b1;
    logic ext_en = 1'b0;
    logic hw_init_n = 1'b1;
    logic [7:0] rd_data = 8'h00;
    logic out_ready = 1'b0;
    logic stall = 1'b1;
    wire cs_n, dc, wr_n, rd_n, pad_clk, osc_out, osc_oe, rd_done, out_valid;
    wire out_is_data, frame_marker, overrun, in_init;
    wire [7:0] pins, bus_out, bus_oe, out_byte;
    wire [8:0] out_col;
    wire [6:0] out_row;
    wire [2:0] active_mode;
    int num_errors = 0;
    int total_checks = 0;
    int rd_cnt = 0;
    int frm_cnt = 0;
    int ecol = 0;
    int erow = 0;
    int e;
    int exp_q[$];
    logic [7:0] v, oe, b;
    logic d;
    logic [2:0] modes[5] = '{3'b110, 3'b010, 3'b100, 3'b000, 3'b001};
    always #5 sys_clk = ~sys_clk;
    ohbfe_top #(.COLS(COLS), .ROWS(ROWS), .DCLK_PER_ROW(2)) u_dut (.sys_clk, .rst,
        .iface_mode_bit0(strap[0]), .iface_mode_bit1(strap[1]), .iface_mode_bit2(strap[2]),
        .internal_osc_select(osel), .osc_io_pad_in(osc_oe ? osc_out : pad_clk),
        .osc_io_pad_out(osc_out), .osc_io_pad_oe(osc_oe), .hw_init_n, .chip_sel_n(cs_n),
        .data_command_select(dc), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n), .bus_in(pins),
        .bus_out, .bus_oe, .rd_data, .rd_done, .out_valid, .out_ready, .out_byte,
        .out_is_data, .out_col, .out_row, .frame_marker, .overrun, .active_mode, .in_init);
    ohbfe_host_model u_host (.sys_clk, .dev_out(bus_out), .dev_oe(bus_oe), .ext_en, .cs_n,
        .dc, .wr_n, .rd_n, .pad_clk, .pins);
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // bounded wait for init done and an empty stream
    task automatic settle();
        repeat (400) begin
            if (in_init === 1'b0 && out_valid === 1'b0 && exp_q.size() == 0) return;
            @(negedge sys_clk);
        end
        check("wait", 32'h1, 32'h0);
        end_of_test();
    endtask
    task automatic init_dev(input logic [2:0] m);
        hw_init_n = 1'b0;
        u_host.hold(2);
        strap = m;
        u_host.rd_n = (m != 3'b100);
        u_host.hold(8);
        hw_init_n = 1'b1;
        ecol = 0;
        erow = 0;
        settle();
    endtask
    task automatic send(input logic m68, input logic sel, input logic d, input logic [7:0] b);
        if (sel) exp_q.push_back({d, b});
        u_host.wr(m68, sel, d, b);
    endtask
    // consumer with random stalls, off the sampling edge
    always @(negedge sys_clk) out_ready <= !stall && $urandom_range(1, 0);
    // reference stream compared at every pop, pixel address at every display data pop
    always @(posedge sys_clk) begin
        if (rd_done === 1'b1) rd_cnt++;
        if ($rose(frame_marker)) frm_cnt++;
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("extra byte", 32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                check("byte", out_byte, e[7:0]);
                check("is data", out_is_data, e[8]);
                if (e[8]) begin
                    check("col", out_col, ecol);
                    check("row", out_row, erow);
                    ecol = (ecol == COLS - 2) ? 0 : ecol + 2;
                    erow = (ecol == 0) ? (erow + 1) % ROWS : erow;
                end
            end
        end
    end
    initial begin
        void'($urandom(85167));
        u_host.hold(8);
        rst = 1'b0;
        foreach (modes[i]) begin
            init_dev(modes[i]);
            check("mode", active_mode, modes[i]);
            check("float", bus_oe, 8'h00);
        end
        $display("test modes finished");
        init_dev(3'b110);
        stall = 1'b0;
        for (int i = 0; i < 14; i++) send(1'b0, i != 5, $urandom_range(3, 0) != 0, 8'($urandom));
        settle();
        stall = 1'b1;
        for (int i = 0; i < 4; i++) send(1'b0, 1'b1, 1'b1, 8'($urandom));
        void'(exp_q.pop_back());
        check("overrun", overrun, 1'b1);
        stall = 1'b0;
        settle();
        init_dev(3'b110);
        check("overrun", overrun, 1'b0);
        rd_data = 8'($urandom);
        u_host.rd(1'b0, v, oe);
        check("read byte", v, rd_data);
        check("read drive", oe, 8'hff);
        check("read done", rd_cnt, 1);
        $display("test parallel 8080 finished");
        init_dev(3'b100);
        for (int i = 0; i < 4; i++) send(1'b1, 1'b1, i % 2 == 0, 8'($urandom));
        settle();
        u_host.rd(1'b1, v, oe);
        check("read byte", v, rd_data);
        check("read drive", oe, 8'hff);
        check("read done", rd_cnt, 2);
        $display("test parallel 6800 finished");
        for (int t = 0; t < 2; t++) begin
            init_dev({2'b00, t == 1});
            for (int i = 0; i < 3; i++) begin
                b = 8'($urandom);
                d = $urandom_range(1, 0);
                exp_q.push_back({d, b});
                u_host.spi(t == 1, d, b);
            end
            settle();
        end
        $display("test serial finished");
        // address matches only when the address pin is high
        init_dev(3'b010);
        for (int t = 0; t < 2; t++) begin
            b = 8'($urandom);
            u_host.dc = t[0];
            if (t == 1) exp_q.push_back({1'b1, b});
            u_host.i2c(8'h7a, 1'b1, 1'b0);
            u_host.i2c(8'h40, 1'b0, 1'b0);
            u_host.i2c(b, 1'b0, 1'b1);
        end
        settle();
        $display("test i2c finished");
        check("pad drive", osc_oe, 1'b1);
        osel = 1'b0;
        ext_en = 1'b1;
        u_host.hold(20);
        frm_cnt = 0;
        u_host.hold(640);
        check("pad float", osc_oe, 1'b0);
        check("frames", frm_cnt inside {[8:11]}, 1'b1);
        ext_en = 1'b0;
        $display("test clock finished");
        end_of_test();
    end
endmodule
`default_nettype wire
